/* File: src/cvl_consts.svh */
// Register offsets, field positions, limits and defaults for the charge voltage limit block
`ifndef CVL_CONSTS_SVH
`define CVL_CONSTS_SVH

`define CVL_ADDR_LIMIT_LOW 8'h04
`define CVL_ADDR_LIMIT_HIGH 8'h05
`define CVL_I2C_DEV_ADDR 7'h09
`define CVL_HIGH_UNUSED_BIT 7
`define CVL_LOW_CODE_LSB 3
`define CVL_CODE_W 12
`define CVL_STEP_MV 8
`define CVL_MIN_MV 1024
`define CVL_MAX_MV 19200
`define CVL_MIN_CODE 12'(`CVL_MIN_MV / `CVL_STEP_MV)
`define CVL_MAX_CODE 12'(`CVL_MAX_MV / `CVL_STEP_MV)
`define CVL_DEF_1CELL_MV 4200
`define CVL_DEF_2CELL_MV 8400
`define CVL_DEF_3CELL_MV 12600
`define CVL_DEF_4CELL_MV 16800
`define CVL_DEF_1CELL_CODE 12'(`CVL_DEF_1CELL_MV / `CVL_STEP_MV)
`define CVL_DEF_2CELL_CODE 12'(`CVL_DEF_2CELL_MV / `CVL_STEP_MV)
`define CVL_DEF_3CELL_CODE 12'(`CVL_DEF_3CELL_MV / `CVL_STEP_MV)
`define CVL_DEF_4CELL_CODE 12'(`CVL_DEF_4CELL_MV / `CVL_STEP_MV)
`define CVL_BIT_CNT_FULL 4'h8

`endif

/* File: src/cvl_pkg.sv */
// Types shared by the charge voltage limit block
package cvl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WRITE,
        ST_READ,
        ST_RACK
    } cvl_i2c_state_t;

    typedef enum logic [1:0] {
        CELLS_1,
        CELLS_2,
        CELLS_3,
        CELLS_4
    } cvl_cells_t;
endpackage

/* File: src/cvl_i2c_slave.sv */
// Byte-level I2C target with register pointer and auto-increment
`include "cvl_consts.svh"

module cvl_i2c_slave (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [7:0] rd_data,
    output logic [7:0] reg_ptr,
    output logic wr_pulse,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic xfer_end
);
    cvl_pkg::cvl_i2c_state_t state_r;
    logic scl_q_r;
    logic sda_q_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [3:0] cnt_r;
    logic rw_r;
    logic first_r;

    wire scl_rise = scl_in & ~scl_q_r;
    wire scl_fall = ~scl_in & scl_q_r;
    wire start_cond = scl_in & scl_q_r & sda_q_r & ~sda_in;
    wire stop_cond = scl_in & scl_q_r & ~sda_q_r & sda_in;
    wire byte_done = scl_fall & (cnt_r == `CVL_BIT_CNT_FULL);
    wire [7:0] shift_nxt = {shift_r[6:0], sda_in};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r <= cvl_pkg::ST_IDLE;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            cnt_r <= 4'h0;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            reg_ptr <= 8'h00;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            wr_pulse <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            xfer_end <= 1'b0;
        end else begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
            wr_pulse <= 1'b0;
            xfer_end <= 1'b0;
            if (start_cond) begin
                // Repeated start also closes the running command
                state_r <= cvl_pkg::ST_ADDR;
                cnt_r <= 4'h0;
                first_r <= 1'b1;
                sda_oe <= 1'b0;
                xfer_end <= 1'b1;
            end else if (stop_cond) begin
                state_r <= cvl_pkg::ST_IDLE;
                sda_oe <= 1'b0;
                xfer_end <= 1'b1;
            end else begin
                case (state_r)
                    cvl_pkg::ST_ADDR: begin
                        if (scl_rise) begin
                            shift_r <= shift_nxt;
                            cnt_r <= cnt_r + 4'h1;
                        end else if (byte_done) begin
                            if (shift_r[7:1] == `CVL_I2C_DEV_ADDR) begin
                                rw_r <= shift_r[0];
                                sda_oe <= 1'b1;
                                state_r <= cvl_pkg::ST_ACK;
                            end else begin
                                state_r <= cvl_pkg::ST_IDLE;
                            end
                        end
                    end
                    cvl_pkg::ST_ACK: begin
                        if (scl_fall) begin
                            if (rw_r) begin
                                sda_oe <= ~rd_data[7];
                                tx_r <= {rd_data[6:0], 1'b0};
                                cnt_r <= 4'h1;
                                state_r <= cvl_pkg::ST_READ;
                            end else begin
                                sda_oe <= 1'b0;
                                cnt_r <= 4'h0;
                                state_r <= cvl_pkg::ST_WRITE;
                            end
                        end
                    end
                    cvl_pkg::ST_WRITE: begin
                        if (scl_rise) begin
                            shift_r <= shift_nxt;
                            cnt_r <= cnt_r + 4'h1;
                        end else if (byte_done) begin
                            if (first_r) begin
                                reg_ptr <= shift_r;
                                first_r <= 1'b0;
                            end else begin
                                wr_pulse <= 1'b1;
                                wr_addr <= reg_ptr;
                                wr_data <= shift_r;
                                reg_ptr <= reg_ptr + 8'h01;
                            end
                            sda_oe <= 1'b1;
                            state_r <= cvl_pkg::ST_ACK;
                        end
                    end
                    cvl_pkg::ST_READ: begin
                        if (byte_done) begin
                            sda_oe <= 1'b0;
                            state_r <= cvl_pkg::ST_RACK;
                        end else if (scl_fall) begin
                            sda_oe <= ~tx_r[7];
                            tx_r <= {tx_r[6:0], 1'b0};
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                    cvl_pkg::ST_RACK: begin
                        if (scl_rise) begin
                            if (sda_in) begin
                                state_r <= cvl_pkg::ST_IDLE;
                            end else begin
                                reg_ptr <= reg_ptr + 8'h01;
                                state_r <= cvl_pkg::ST_ACK;
                            end
                        end
                    end
                    default: begin
                        state_r <= cvl_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* File: src/cvl_charge_voltage.sv */
// Charge voltage limit register pair with range check, pin default and charge gating
//
// What this block does
// R01 - Limit is 12 bits over a low and a high byte, written as one command.
// R02 - Settable range 1.024 V to 19.200 V in 8 mV steps.
// R03 - Nonzero writes outside the range are dropped; previous setting stays.
// R04 - Power-on default from cell pin: 4200, 8400, 12600 or 16800 mV.
// R05 - Charging starts only on a host current write once adapter is good.
// R06 - Host programs the limit before charge current for non-4.2 V cells.
// R07 - Writing zero restores the pin default and forces charge current to zero.
// R08 - High byte bits 6..0 weigh 16384 mV down to 256 mV.
// R09 - Low byte bits 7..3 weigh 128 mV down to 8 mV.
// R10 - High byte bit 7 unused; a one there makes the write invalid.
// R11 - Low byte bits 2..0 unused and ignored.
// R12 - After reset charge current is held at zero until the host writes it.
// R13 - Checks apply to the joined value after both bytes of one command.
`include "cvl_consts.svh"

module cvl_charge_voltage (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] cell_count_select_pin,
    input wire logic adapter_good_signal,
    input wire logic charge_current_wr_nonzero,
    output logic [11:0] charge_voltage_limit_r,
    output logic charge_current_clear_r,
    output logic charge_enable_r
);
    logic [7:0] reg_ptr;
    logic wr_pulse;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic xfer_end;
    logic [7:0] stage_low_r;
    logic [7:0] stage_high_r;
    logic got_low_r;
    logic got_high_r;
    logic init_pending_r;

    // Default code for the strapped cell count
    function automatic logic [11:0] cvl_default_code(input logic [1:0] cells);
        case (cvl_pkg::cvl_cells_t'(cells))
            cvl_pkg::CELLS_1: cvl_default_code = `CVL_DEF_1CELL_CODE;
            cvl_pkg::CELLS_2: cvl_default_code = `CVL_DEF_2CELL_CODE;
            cvl_pkg::CELLS_3: cvl_default_code = `CVL_DEF_3CELL_CODE;
            cvl_pkg::CELLS_4: cvl_default_code = `CVL_DEF_4CELL_CODE;
            default: cvl_default_code = `CVL_DEF_1CELL_CODE;
        endcase
    endfunction

    // Readback: code in bits 11..5 high and 4..0 low, unused bits zero
    wire [7:0] rd_low = {charge_voltage_limit_r[4:0], 3'b000}; // see R09 see R11
    wire [7:0] rd_high = {1'b0, charge_voltage_limit_r[11:5]}; // see R08
    wire [7:0] rd_byte = (reg_ptr == `CVL_ADDR_LIMIT_LOW) ? rd_low :
                         (reg_ptr == `CVL_ADDR_LIMIT_HIGH) ? rd_high : 8'h00;

    cvl_i2c_slave u_i2c (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .rd_data(rd_byte),
        .reg_ptr(reg_ptr),
        .wr_pulse(wr_pulse),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .xfer_end(xfer_end)
    );

    wire wr_low = wr_pulse & (wr_addr == `CVL_ADDR_LIMIT_LOW);
    wire wr_high = wr_pulse & (wr_addr == `CVL_ADDR_LIMIT_HIGH);

    // Joined value only counts once both halves of one command are in
    wire commit = xfer_end & got_low_r & got_high_r; // see R01 see R13
    wire [11:0] new_code = {stage_high_r[6:0], stage_low_r[7:`CVL_LOW_CODE_LSB]}; // see R08 see R09 see R11
    wire high_bad = stage_high_r[`CVL_HIGH_UNUSED_BIT]; // see R10
    wire is_zero = ~high_bad & (new_code == 12'h000);
    wire in_range = (new_code >= `CVL_MIN_CODE) & (new_code <= `CVL_MAX_CODE); // see R02 see R03
    wire take_code = commit & ~high_bad & in_range;
    wire take_zero = commit & is_zero; // see R07

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stage_low_r <= 8'h00;
            stage_high_r <= 8'h00;
            got_low_r <= 1'b0;
            got_high_r <= 1'b0;
        end else if (xfer_end) begin
            got_low_r <= 1'b0;
            got_high_r <= 1'b0;
        end else begin
            if (wr_low) begin
                stage_low_r <= wr_data;
                got_low_r <= 1'b1;
            end
            if (wr_high) begin
                stage_high_r <= wr_data;
                got_high_r <= 1'b1;
            end
        end
    end

    // Strap is sampled the cycle after reset release, not under reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            init_pending_r <= 1'b1;
            charge_voltage_limit_r <= 12'h000;
        end else if (init_pending_r) begin
            init_pending_r <= 1'b0;
            charge_voltage_limit_r <= cvl_default_code(cell_count_select_pin); // see R04
        end else if (take_zero) begin
            charge_voltage_limit_r <= cvl_default_code(cell_count_select_pin); // see R07
        end else if (take_code) begin
            charge_voltage_limit_r <= new_code; // see R03
        end
    end

    // Zero-write clear beats a same-cycle current write
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            charge_current_clear_r <= 1'b1; // see R12
            charge_enable_r <= 1'b0; // see R12
        end else begin
            charge_current_clear_r <= take_zero; // see R07
            if (take_zero || !adapter_good_signal) begin
                charge_enable_r <= 1'b0;
            end else if (charge_current_wr_nonzero) begin
                charge_enable_r <= 1'b1; // see R05
            end
        end
    end
endmodule

/* File: sim/cvl_monitor.sv */
// Port-level assertions for the charge voltage limit block
`include "cvl_consts.svh"

module cvl_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [1:0] cell_count_select_pin,
    input wire logic adapter_good_signal,
    input wire logic charge_current_wr_nonzero,
    input wire logic [11:0] charge_voltage_limit_r,
    input wire logic charge_current_clear_r,
    input wire logic charge_enable_r
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    function automatic logic [11:0] def_code(input logic [1:0] p);
        case (p)
            2'h0: return `CVL_DEF_1CELL_CODE;
            2'h1: return `CVL_DEF_2CELL_CODE;
            2'h2: return `CVL_DEF_3CELL_CODE;
            default: return `CVL_DEF_4CELL_CODE;
        endcase
    endfunction

    limit_in_range_a: assert property ($past(rst_n) |-> charge_voltage_limit_r >= `CVL_MIN_CODE
        && charge_voltage_limit_r <= `CVL_MAX_CODE) else $error("limit outside range");
    reset_default_a: assert property ($rose(rst_n) |=>
        charge_voltage_limit_r == def_code(cell_count_select_pin)) else $error("wrong reset default");
    reset_clear_a: assert property (disable iff (1'b0) !rst_n |=> charge_current_clear_r)
        else $error("clear missing in reset");
    reset_no_charge_a: assert property (disable iff (1'b0) !rst_n |=> !charge_enable_r)
        else $error("charging in reset");
    zero_stops_charge_a: assert property (charge_current_clear_r && $past(rst_n) |-> !charge_enable_r)
        else $error("charging during clear");
    zero_restores_default_a: assert property (charge_current_clear_r && $past(rst_n) |->
        charge_voltage_limit_r == def_code(cell_count_select_pin)) else $error("zero write default wrong");
    charge_start_cause_a: assert property ($rose(charge_enable_r) |->
        $past(charge_current_wr_nonzero) && $past(adapter_good_signal)) else $error("charge start uncaused");
    charge_start_a: assert property (charge_current_wr_nonzero && adapter_good_signal |=>
        charge_enable_r || charge_current_clear_r) else $error("charge did not start");
    adapter_stop_a: assert property (!adapter_good_signal |=> !charge_enable_r)
        else $error("charging without adapter");
    commit_at_stop_a: assert property ($changed(charge_voltage_limit_r) && $past(rst_n, 2) |->
        $past(scl_in, 2)) else $error("limit changed mid command");
endmodule

bind cvl_charge_voltage cvl_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .cell_count_select_pin(cell_count_select_pin),
    .adapter_good_signal(adapter_good_signal), .charge_current_wr_nonzero(charge_current_wr_nonzero),
    .charge_voltage_limit_r(charge_voltage_limit_r), .charge_current_clear_r(charge_current_clear_r),
    .charge_enable_r(charge_enable_r));

/* File: sim/cvl_host_model.sv */
// Host-side I2C master that writes the limit registers
`include "cvl_consts.svh"

module cvl_host_model (
    input wire logic core_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Three core clocks per phase keeps SDA well away from SCL edges
    task automatic tick();
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic put_bit(input logic b);
        sda_pull = ~b;
        tick();
        scl = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask
    int nack_cnt = 0;
    // Line is sampled at the end of the high phase, where the target holds it
    task automatic get_bit(output logic b);
        sda_pull = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        b = sda;
        scl = 1'b0;
        tick();
    endtask
    task automatic put_byte(input logic [7:0] b);
        logic ack;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        get_bit(ack);
        if (ack) begin
            nack_cnt++;
        end
    endtask
    task automatic get_byte(output logic [7:0] d, input logic last);
        logic bit_v;
        for (int i = 7; i >= 0; i--) begin
            get_bit(bit_v);
            d[i] = bit_v;
        end
        put_bit(last);
    endtask
    // Both bytes go in one command when n > 1, so the joined value is checked once
    task automatic write(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1, input int n);
        sda_pull = 1'b1;
        tick();
        scl = 1'b0;
        tick();
        put_byte({`CVL_I2C_DEV_ADDR, 1'b0});
        put_byte(ptr);
        put_byte(d0);
        if (n > 1) begin
            put_byte(d1);
        end
        sda_pull = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_pull = 1'b0;
        tick();
    endtask
    // Pointer write, repeated start, then two bytes: ACK the first, NACK the last
    task automatic read(input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1);
        sda_pull = 1'b1;
        tick();
        scl = 1'b0;
        tick();
        put_byte({`CVL_I2C_DEV_ADDR, 1'b0});
        put_byte(ptr);
        sda_pull = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_pull = 1'b1;
        tick();
        scl = 1'b0;
        tick();
        put_byte({`CVL_I2C_DEV_ADDR, 1'b1});
        get_byte(d0, 1'b0);
        get_byte(d1, 1'b1);
        sda_pull = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_pull = 1'b0;
        tick();
    endtask
endmodule

/* File: sim/test_max_charge_voltage_register.sv */
// Self-checking bench for the charge voltage limit block
`include "cvl_consts.svh"

module test_max_charge_voltage_register;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, scl, sda_pull, sda_out, sda_oe, sda, adapter_good, wr_nz, clr_r, en_r, clr_seen;
    logic [1:0] pin;
    logic [11:0] lim_r, cur, code;
    logic [11:0] tc [7] = '{12'h07F, 12'h080, 12'h960, 12'h961, 12'h3E8, 12'h5DC, 12'h258};
    logic [6:0] tc_ok = 7'b1000110;
    logic [13:0] exp_q [$];
    logic [7:0] rd_lo, rd_hi;
    int n_fail, cmp_count, cycles;
    event chk_ev;

    // Open drain wire with pull-up
    assign sda = sda_pull ? 1'b0 : (sda_oe ? sda_out : 1'b1);
    cvl_charge_voltage u_dut (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .cell_count_select_pin(pin), .adapter_good_signal(adapter_good),
        .charge_current_wr_nonzero(wr_nz), .charge_voltage_limit_r(lim_r), .charge_current_clear_r(clr_r),
        .charge_enable_r(en_r));
    cvl_host_model u_host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (clr_r === 1'b1) clr_seen <= 1'b1;
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            print_verdict();
        end
    end

    function automatic logic [11:0] def_code(input logic [1:0] p);
        case (p)
            2'h0: return `CVL_DEF_1CELL_CODE;
            2'h1: return `CVL_DEF_2CELL_CODE;
            2'h2: return `CVL_DEF_3CELL_CODE;
            default: return `CVL_DEF_4CELL_CODE;
        endcase
    endfunction
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic note(input logic en, input logic clr, input logic [11:0] c);
        exp_q.push_back({en, clr, c});
        ->chk_ev;
    endtask
    task automatic do_reset(input logic [1:0] p);
        rst_n = 1'b0;
        pin = p;
        step(6);
        rst_n = 1'b1;
        step(2);
        cur = def_code(p);
        note(1'b0, 1'b1, cur);
    endtask
    task automatic cmd(input logic [11:0] c, input logic bad, input int n);
        u_host.write(8'h04, {c[4:0], 3'($urandom)}, {bad, c[11:5]}, n);
        step(4);
    endtask
    task automatic pulse_current();
        wr_nz = 1'b1;
        step(1);
        wr_nz = 1'b0;
        step(1);
    endtask

    initial begin
        logic [13:0] n;
        forever begin
            @(chk_ev);
            n = exp_q.pop_front();
            check("limit", lim_r, n[11:0]);
            check("clear", {11'h000, clr_seen}, {11'h000, n[12]});
            check("enable", {11'h000, en_r}, {11'h000, n[13]});
            clr_seen = 1'b0;
        end
    end

    initial begin
        rst_n = 1'b0;
        pin = 2'h0;
        adapter_good = 1'b0;
        wr_nz = 1'b0;
        clr_seen = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        cycles = 0;
        void'($urandom(32'hBAF6A47A));
        for (int p = 0; p < 4; p++) do_reset(2'(p));
        // Range edges, reserved bit set, single byte command
        for (int i = 0; i < 7; i++) begin
            cmd(tc[i], i == 4, (i == 5) ? 1 : 2);
            if (tc_ok[i]) cur = tc[i];
            note(1'b0, 1'b0, cur);
        end
        repeat (6) begin
            code = 12'(128 + $urandom_range(2272));
            cmd(code, 1'b0, 2);
            cur = code;
            note(1'b0, 1'b0, cur);
            u_host.read(8'h04, rd_lo, rd_hi);
            check("read low", {4'h0, rd_lo}, {4'h0, cur[4:0], 3'b000});
            check("read high", {4'h0, rd_hi}, {5'h00, cur[11:5]});
        end
        // Limit first, then current write, as a host must
        adapter_good = 1'b1;
        pulse_current();
        note(1'b1, 1'b0, cur);
        pin = 2'($urandom);
        step(1);
        cmd(12'h000, 1'b0, 2);
        cur = def_code(pin);
        note(1'b0, 1'b1, cur);
        pulse_current();
        adapter_good = 1'b0;
        step(2);
        note(1'b0, 1'b0, cur);
        pulse_current();
        note(1'b0, 1'b0, cur);
        do_reset(2'($urandom));
        step(2);
        check("ack", 12'(u_host.nack_cnt), 12'h000);
        print_verdict();
    end
endmodule
